/* pkg/glv_pkg.sv */
// Operation
// (RULE1) Filter mode 00: loop and converter readback both use raw samples.
// (RULE2) Mode 01: raw loop input; filtered readback refreshed only when that register is read.
// (RULE3) Mode 10: raw loop, readback refreshed each loop tick; mode 11 filters both.
// (RULE4) Converter reference power bit resets high; clearing it powers the reference down.
// (RULE5) Three 2-bit fields order amp, mixer, filter steps; reset 2, 1, 3.
// (RULE6) Permit bit allows one extra lower front amplifier step.
// (RULE7) Prohibit bit keeps the loop out of its highest overall gain.
// (RULE8) Loop operation: 0 free run, 1 manual, 2 hold, 3 lock after preamble.
// (RULE9) Carrier offset readback is 8-bit two's complement, 1 kHz per unit.
// (RULE10) Band enable set: band taken from override register, else calibrated band.
// (RULE11) Bias enable set: bias DAC from override register, else calibrated bias.
// (RULE12) Four-bit field gives Q phase level control reference.
// (RULE13) Calibration setup 0xF skips calibration on transmit and receive entry.
// (RULE14) Calibration setup 0x1, the reset value, calibrates on every such entry.
// (RULE15) Three-bit word sets main crystal oscillator tuning capacitance.
// (RULE16) Manual mode applies the mode register gain fields directly, status encodings.
// (RULE17) Gain status always shows the applied amp, mixer and filter steps.
// (RULE18) Free run raises gain below low limit, lowers above high limit.
package glv_pkg;
	localparam logic [9:0] ADDR_ADC_FILTER = 10'h35a;
	localparam logic [9:0] ADDR_LOOP_CFG = 10'h35c;
	localparam logic [9:0] ADDR_LOOP_MODE = 10'h35d;
	localparam logic [9:0] ADDR_LOW_LIMIT = 10'h35e;
	localparam logic [9:0] ADDR_HIGH_LIMIT = 10'h35f;
	localparam logic [9:0] ADDR_GAIN_STATUS = 10'h360;
	localparam logic [9:0] ADDR_OFFSET_RB = 10'h372;
	localparam logic [9:0] ADDR_ADC_RB = 10'h3f0;
	localparam logic [9:0] ADDR_BAND_OVR = 10'h3cb;
	localparam logic [9:0] ADDR_BIAS_OVR = 10'h3cc;
	localparam logic [9:0] ADDR_OVR_EN = 10'h3cd;
	localparam logic [9:0] ADDR_CAL_SETUP = 10'h3d0;
	localparam logic [9:0] ADDR_XTAL = 10'h3d2;

	localparam logic [7:0] RST_ADC_FILTER = 8'h11;
	localparam logic [7:0] RST_LOOP_CFG = 8'h9c;
	localparam logic [7:0] RST_LOOP_MODE = 8'h00;
	localparam logic [7:0] RST_LOW_LIMIT = 8'h37;
	localparam logic [7:0] RST_HIGH_LIMIT = 8'h69;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CAL_SETUP = 8'h01;

	localparam int FILT_MODE_LSB = 5;
	localparam int REF_PWR_BIT = 4;
	localparam int FA_ORDER_LSB = 6;
	localparam int MX_ORDER_LSB = 4;
	localparam int FL_ORDER_LSB = 2;
	localparam int XLOW_PERMIT_BIT = 1;
	localparam int MAX_PROHIBIT_BIT = 0;
	localparam int OPER_LSB = 5;
	localparam int FA_MAN_LSB = 3;
	localparam int MX_MAN_BIT = 2;
	localparam int FL_MAN_LSB = 0;
	localparam int BIAS_EN_BIT = 1;
	localparam int BAND_EN_BIT = 0;
	localparam int QREF_LSB = 2;
	localparam int CAL_LSB = 0;
	localparam int XTAL_LSB = 3;
	localparam int FILT_SHIFT = 2;

	localparam logic [1:0] FMODE_NONE = 2'h0;
	localparam logic [1:0] FMODE_ON_READ = 2'h1;
	localparam logic [1:0] FMODE_ON_TICK = 2'h2;
	localparam logic [1:0] FMODE_BOTH = 2'h3;
	localparam logic [3:0] CAL_BYPASS = 4'hf;

	localparam logic [1:0] FA_MAX = 2'h2;
	localparam logic [1:0] FL_MAX = 2'h2;

	localparam int CLK_HZ = 10000000;
	localparam int LOOP_TICK_HZ = 40625;
	localparam int LOOP_TICK_CYCLES = CLK_HZ / LOOP_TICK_HZ;

	typedef enum logic [1:0] {GLV_FREE, GLV_MANUAL, GLV_HOLD, GLV_LOCK} glv_oper_e;
endpackage

/* testbench/gain_loop_and_vco_cal_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module gain_loop_and_vco_cal_regs_test;
	import glv_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic pre = 1'b0;
	logic ent = 1'b0;
	logic rd_seen = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [7:0] wdat = 8'h00;
	logic [7:0] adc = 8'h50;
	logic [7:0] coff = 8'hc3;
	logic [7:0] cband = 8'h5a;
	logic [7:0] cbias = 8'ha5;
	logic [7:0] rdat, band, bias, v;
	logic [1:0] fas, fls;
	logic mxs, xlow, refp, cst;
	logic [3:0] qref;
	logic [2:0] trim;
	logic [31:0] seed = 32'h0000_0038;
	logic [7:0] exp_q[$];
	int bad_count = 0;
	int checks = 0;
	logic [9:0] ta[10] = '{ADDR_ADC_FILTER, ADDR_LOOP_CFG, ADDR_LOOP_MODE, ADDR_LOW_LIMIT,
		ADDR_HIGH_LIMIT, ADDR_BAND_OVR, ADDR_BIAS_OVR, ADDR_OVR_EN, ADDR_CAL_SETUP, ADDR_XTAL};
	logic [7:0] tr[10] = '{8'h11, 8'h9c, 8'h00, 8'h37, 8'h69, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

	always #50 clk = ~clk;

	glv_regs #(.TICK_CYCLES(4)) i_dut (
		.clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdat), .reg_wr(wr_s),
		.reg_rd(rd_s), .reg_rdata(rdat), .adc_sample(adc), .preamble_detect(pre),
		.carrier_offset_in(coff), .converter_reference_power(refp), .front_amp_step(fas),
		.front_amp_extra_low(xlow), .mixer_step(mxs), .filter_step(fls), .cal_band(cband),
		.cal_bias(cbias), .enter_tx_rx(ent), .osc_band(band), .osc_bias(bias),
		.osc_q_phase_level_ref(qref), .osc_cal_start(cst), .crystal_trim_word(trim)
	);

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatched %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		rd_s <= 1'b0;
	endtask

	// Bounded wait on {extra low, amp, mixer, filter}
	task automatic wait_st(input logic [5:0] e);
		int n;
		n = 0;
		while ({xlow, fas, mxs, fls} !== e && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		cmp("gain steps", {2'b00, e}, {2'b00, xlow, fas, mxs, fls});
		if (n >= 400)
			print_verdict();
	endtask

	// Read answers land one cycle after the strobe
	always @(posedge clk)
		rd_seen <= rd_s;
	always @(negedge clk)
		if (rd_seen && exp_q.size() > 0)
			cmp("reg_rdata", exp_q.pop_front(), rdat);

	initial
	begin
		#2_000_000;
		bad_count++;
		print_verdict();
	end

	initial
	begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		cband <= rnd();
		cbias <= rnd();
		coff <= rnd();
		for (int i = 0; i < 10; i++)
			rd(ta[i], tr[i]);
		cmp("ref power", 8'h01, {7'h00, refp});
		wr(ADDR_GAIN_STATUS, 8'hff);
		rd(ADDR_GAIN_STATUS, 8'h00);
		rd(ADDR_OFFSET_RB, coff);
		rd(ADDR_ADC_RB, adc);
		rd(10'h000, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			v = rnd();
			wr(ta[i], v);
			rd(ta[i], v);
		end
		wr(ADDR_BAND_OVR, 8'h3c);
		wr(ADDR_BIAS_OVR, 8'hc3);
		wr(ADDR_OVR_EN, 8'h2b);
		repeat (2) @(negedge clk);
		cmp("osc_band", 8'h3c, band);
		cmp("osc_bias", 8'hc3, bias);
		cmp("q level ref", 8'h0a, {4'h0, qref});
		wr(ADDR_OVR_EN, 8'h00);
		repeat (2) @(negedge clk);
		cmp("osc_band", cband, band);
		cmp("osc_bias", cbias, bias);
		wr(ADDR_XTAL, 8'h28);
		@(negedge clk);
		cmp("crystal trim", 8'h05, {5'h00, trim});
		for (int i = 0; i < 2; i++)
		begin
			wr(ADDR_CAL_SETUP, (i == 0) ? 8'h01 : 8'h0f);
			@(posedge clk);
			ent <= 1'b1;
			@(posedge clk);
			ent <= 1'b0;
			@(negedge clk);
			cmp("cal start", {7'h00, i == 0}, {7'h00, cst});
		end
		wr(ADDR_LOOP_MODE, 8'h35);
		rd(ADDR_GAIN_STATUS, 8'h15);
		wr(ADDR_ADC_FILTER, 8'h11);
		wr(ADDR_LOW_LIMIT, 8'h37);
		wr(ADDR_HIGH_LIMIT, 8'h69);
		wr(ADDR_LOOP_CFG, 8'h9c);
		adc <= 8'h00;
		wr(ADDR_LOOP_MODE, 8'h00);
		wait_st(6'h16);
		adc <= 8'hff;
		wr(ADDR_LOOP_CFG, 8'h9e);
		wait_st(6'h20);
		wr(ADDR_LOOP_CFG, 8'h9d);
		adc <= 8'h00;
		wait_st(6'h15);
		repeat (40) @(posedge clk);
		rd(ADDR_GAIN_STATUS, 8'h15);
		wr(ADDR_LOOP_MODE, 8'h40);
		adc <= 8'hff;
		repeat (40) @(posedge clk);
		rd(ADDR_GAIN_STATUS, 8'h15);
		adc <= 8'h50;
		pre <= 1'b1;
		wr(ADDR_LOOP_MODE, 8'h60);
		@(posedge clk);
		pre <= 1'b0;
		adc <= 8'hff;
		repeat (40) @(posedge clk);
		rd(ADDR_GAIN_STATUS, 8'h15);
		wr(ADDR_LOOP_MODE, 8'h00);
		wait_st(6'h00);
		// Filter settles to exactly 0 from above and stalls at 0xfc from 0
		wr(ADDR_ADC_FILTER, 8'h61);
		adc <= 8'h00;
		@(negedge clk);
		cmp("ref power", 8'h00, {7'h00, refp});
		repeat (200) @(posedge clk);
		rd(ADDR_ADC_RB, 8'h00);
		adc <= 8'hff;
		repeat (200) @(posedge clk);
		rd(ADDR_ADC_RB, 8'hfc);
		wr(ADDR_ADC_FILTER, 8'h51);
		adc <= 8'h00;
		repeat (200) @(posedge clk);
		rd(ADDR_ADC_RB, 8'h00);
		wr(ADDR_ADC_FILTER, 8'h31);
		adc <= 8'hff;
		repeat (200) @(posedge clk);
		rd(ADDR_ADC_RB, 8'hfc);
		repeat (2) @(posedge clk);
		print_verdict();
	end
endmodule
`default_nettype wire

/* testbench/glv_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module glv_regs_assertions
	import glv_pkg::*;
#(
	parameter int TICK_CYCLES = LOOP_TICK_CYCLES
)
(
	// Clock, reset and write side of the register port
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	// Inputs and outputs watched
	input wire logic [7:0] cal_band,
	input wire logic [7:0] cal_bias,
	input wire logic enter_tx_rx,
	input wire logic converter_reference_power,
	input wire logic [1:0] front_amp_step,
	input wire logic mixer_step,
	input wire logic [1:0] filter_step,
	input wire logic [7:0] osc_band,
	input wire logic [7:0] osc_bias,
	input wire logic [3:0] osc_q_phase_level_ref,
	input wire logic osc_cal_start,
	input wire logic [2:0] crystal_trim_word
);
	logic live_q;
	logic [7:0] adcf_q, cfg_q, mode_q, band_q, bias_q, ovr_q, cal_q, xtal_q;
	wire logic all_max = front_amp_step == FA_MAX && mixer_step && filter_step == FL_MAX;
	wire logic band_en = ovr_q[BAND_EN_BIT];
	wire logic bias_en = ovr_q[BIAS_EN_BIT];
	wire logic [3:0] cal_sel = cal_q[3:0];

	// Mirror of written registers; live_q masks the first edge after reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			live_q <= 1'b0;
			adcf_q <= RST_ADC_FILTER;
			cfg_q <= RST_LOOP_CFG;
			mode_q <= RST_LOOP_MODE;
			band_q <= RST_ZERO;
			bias_q <= RST_ZERO;
			ovr_q <= RST_ZERO;
			cal_q <= RST_CAL_SETUP;
			xtal_q <= RST_ZERO;
		end
		else
		begin
			live_q <= 1'b1;
			if (reg_wr)
			begin
				case (reg_addr)
					ADDR_ADC_FILTER: adcf_q <= reg_wdata;
					ADDR_LOOP_CFG: cfg_q <= reg_wdata;
					ADDR_LOOP_MODE: mode_q <= reg_wdata;
					ADDR_BAND_OVR: band_q <= reg_wdata;
					ADDR_BIAS_OVR: bias_q <= reg_wdata;
					ADDR_OVR_EN: ovr_q <= reg_wdata;
					ADDR_CAL_SETUP: cal_q <= reg_wdata;
					ADDR_XTAL: xtal_q <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_band;
		live_q |-> osc_band == ($past(band_en) ? $past(band_q) : $past(cal_band));
	endproperty
	a_band: assert property (p_band) else $error("band output wrong");
	property p_bias;
		live_q |-> osc_bias == ($past(bias_en) ? $past(bias_q) : $past(cal_bias));
	endproperty
	a_bias: assert property (p_bias) else $error("bias output wrong");
	property p_cal;
		live_q |-> osc_cal_start == ($past(enter_tx_rx) && $past(cal_sel) != CAL_BYPASS);
	endproperty
	a_cal: assert property (p_cal) else $error("calibration start wrong");
	property p_qref;
		osc_q_phase_level_ref == ovr_q[QREF_LSB +: 4];
	endproperty
	a_qref: assert property (p_qref) else $error("q level reference wrong");
	property p_trim;
		crystal_trim_word == xtal_q[XTAL_LSB +: 3];
	endproperty
	a_trim: assert property (p_trim) else $error("crystal trim wrong");
	property p_refpwr;
		converter_reference_power == adcf_q[REF_PWR_BIT];
	endproperty
	a_refpwr: assert property (p_refpwr) else $error("reference power wrong");
	property p_manual;
		live_q && $past(mode_q) == mode_q && mode_q[6:5] == GLV_MANUAL |->
			front_amp_step == mode_q[4:3] && mixer_step == mode_q[2] && filter_step == mode_q[1:0];
	endproperty
	a_manual: assert property (p_manual) else $error("manual steps wrong");
	property p_hold;
		live_q && $past(mode_q) == mode_q && mode_q[6:5] == GLV_HOLD |->
			$stable(front_amp_step) && $stable(mixer_step) && $stable(filter_step);
	endproperty
	a_hold: assert property (p_hold) else $error("steps moved in hold");
	property p_nomax;
		live_q && cfg_q[MAX_PROHIBIT_BIT] && $past(cfg_q) == cfg_q && $past(mode_q) == mode_q
			&& mode_q[6:5] != GLV_MANUAL && !$past(all_max) |-> !all_max;
	endproperty
	a_nomax: assert property (p_nomax) else $error("highest gain reached");

	c_manual: cover property (mode_q[6:5] == GLV_MANUAL && mixer_step);
	c_cal: cover property (osc_cal_start);
	c_max: cover property (all_max);
endmodule

bind glv_regs glv_regs_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_glv_chk (
	.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.cal_band(cal_band), .cal_bias(cal_bias), .enter_tx_rx(enter_tx_rx),
	.converter_reference_power(converter_reference_power), .front_amp_step(front_amp_step),
	.mixer_step(mixer_step), .filter_step(filter_step), .osc_band(osc_band),
	.osc_bias(osc_bias), .osc_q_phase_level_ref(osc_q_phase_level_ref),
	.osc_cal_start(osc_cal_start), .crystal_trim_word(crystal_trim_word)
);
`default_nettype wire

/* verilog/glv_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module glv_regs
	import glv_pkg::*;
#(
	parameter int TICK_CYCLES = LOOP_TICK_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Converter and receive path
	input wire logic [7:0] adc_sample,
	input wire logic preamble_detect,
	input wire logic [7:0] carrier_offset_in,
	output logic converter_reference_power,
	output logic [1:0] front_amp_step,
	output logic front_amp_extra_low,
	output logic mixer_step,
	output logic [1:0] filter_step,
	// Oscillator
	input wire logic [7:0] cal_band,
	input wire logic [7:0] cal_bias,
	input wire logic enter_tx_rx,
	output logic [7:0] osc_band,
	output logic [7:0] osc_bias,
	output logic [3:0] osc_q_phase_level_ref,
	output logic osc_cal_start,
	output logic [2:0] crystal_trim_word
);
	logic [7:0] adc_cfg_q;
	logic [7:0] loop_cfg_q;
	logic [7:0] loop_mode_q;
	logic [7:0] low_limit_q;
	logic [7:0] high_limit_q;
	logic [7:0] band_ovr_q;
	logic [7:0] bias_ovr_q;
	logic [7:0] ovr_en_q;
	logic [7:0] cal_setup_q;
	logic [7:0] xtal_q;
	logic [7:0] offset_rb_q;
	logic [7:0] adc_rb_q;
	logic [7:0] adc_meta_q;
	logic [7:0] adc_sync_q;
	logic [7:0] filt_q;
	logic [7:0] filt_d;
	logic [15:0] tick_cnt_q;
	logic tick;
	logic [1:0] fa_q;
	logic mx_q;
	logic [1:0] fl_q;
	logic xlow_q;
	logic locked_q;
	logic [1:0] fmode;
	glv_oper_e oper;
	logic [7:0] loop_in;
	logic [2:0] at_max;
	logic [2:0] at_min;
	logic [2:0] up_pick;
	logic [2:0] dn_pick;
	logic raise;
	logic lower;
	logic would_max;

	// Pick the stage whose order value is lowest (up) or highest (down) among movable ones
	function automatic logic [2:0] stage_pick(input logic [7:0] cfg, input logic [2:0] movable,
			input logic up);
		logic [2:0] pick;
		logic [1:0] ord [3];
		pick = 3'b000;
		ord[2] = cfg[FA_ORDER_LSB +: 2];
		ord[1] = cfg[MX_ORDER_LSB +: 2];
		ord[0] = cfg[FL_ORDER_LSB +: 2];
		for (int p = 0; p < 4; p++)
		begin
			for (int s = 2; s >= 0; s--)
			begin
				if (pick == 3'b000 && movable[s] && ord[s] == (up ? 2'(p) : 2'(3 - p)))
				begin
					pick[s] = 1'b1;
				end
			end
		end
		return pick;
	endfunction

	function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
		return a == target;
	endfunction

	assign fmode = adc_cfg_q[FILT_MODE_LSB +: 2];
	assign oper = glv_oper_e'(loop_mode_q[OPER_LSB +: 2]);

	// Write side of the configuration registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			adc_cfg_q <= RST_ADC_FILTER;
			loop_cfg_q <= RST_LOOP_CFG; // RULE5
			loop_mode_q <= RST_LOOP_MODE;
			low_limit_q <= RST_LOW_LIMIT;
			high_limit_q <= RST_HIGH_LIMIT;
			band_ovr_q <= RST_ZERO;
			bias_ovr_q <= RST_ZERO;
			ovr_en_q <= RST_ZERO;
			cal_setup_q <= RST_CAL_SETUP; // RULE14
			xtal_q <= RST_ZERO;
		end
		else if (reg_wr)
		begin
			if (hit(reg_addr, ADDR_ADC_FILTER))
				adc_cfg_q <= reg_wdata;
			if (hit(reg_addr, ADDR_LOOP_CFG))
				loop_cfg_q <= reg_wdata;
			if (hit(reg_addr, ADDR_LOOP_MODE))
				loop_mode_q <= reg_wdata;
			if (hit(reg_addr, ADDR_LOW_LIMIT))
				low_limit_q <= reg_wdata;
			if (hit(reg_addr, ADDR_HIGH_LIMIT))
				high_limit_q <= reg_wdata;
			if (hit(reg_addr, ADDR_BAND_OVR))
				band_ovr_q <= reg_wdata;
			if (hit(reg_addr, ADDR_BIAS_OVR))
				bias_ovr_q <= reg_wdata;
			if (hit(reg_addr, ADDR_OVR_EN))
				ovr_en_q <= reg_wdata;
			if (hit(reg_addr, ADDR_CAL_SETUP))
				cal_setup_q <= reg_wdata;
			if (hit(reg_addr, ADDR_XTAL))
				xtal_q <= reg_wdata;
		end
	end

	// Read port, data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata <= RST_ZERO;
		end
		else if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_ADC_FILTER: reg_rdata <= adc_cfg_q;
				ADDR_LOOP_CFG: reg_rdata <= loop_cfg_q;
				ADDR_LOOP_MODE: reg_rdata <= loop_mode_q;
				ADDR_LOW_LIMIT: reg_rdata <= low_limit_q;
				ADDR_HIGH_LIMIT: reg_rdata <= high_limit_q;
				ADDR_GAIN_STATUS: reg_rdata <= {3'b000, fa_q, mx_q, fl_q}; // RULE17
				ADDR_OFFSET_RB: reg_rdata <= offset_rb_q; // RULE9
				// Mode 01 returns the filter value taken by this very read
				ADDR_ADC_RB: reg_rdata <= (fmode == FMODE_ON_READ) ? filt_q : adc_rb_q; // RULE2
				ADDR_BAND_OVR: reg_rdata <= band_ovr_q;
				ADDR_BIAS_OVR: reg_rdata <= bias_ovr_q;
				ADDR_OVR_EN: reg_rdata <= ovr_en_q;
				ADDR_CAL_SETUP: reg_rdata <= cal_setup_q;
				ADDR_XTAL: reg_rdata <= xtal_q;
				default: reg_rdata <= RST_ZERO;
			endcase
		end
		else
		begin
			reg_rdata <= RST_ZERO;
		end
	end

	// Converter word comes from the analogue side
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			adc_meta_q <= RST_ZERO;
			adc_sync_q <= RST_ZERO;
		end
		else
		begin
			adc_meta_q <= adc_sample;
			adc_sync_q <= adc_meta_q;
		end
	end

	// Loop tick divider
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tick_cnt_q <= 16'h0000;
		else if (tick)
			tick_cnt_q <= 16'h0000;
		else
			tick_cnt_q <= tick_cnt_q + 16'h0001;
	end
	assign tick = tick_cnt_q == 16'(TICK_CYCLES - 1);

	// First-order smoothing; quarter step trades settling speed for noise
	always_comb
	begin
		logic [9:0] diff;
		diff = {2'b00, adc_sync_q} - {2'b00, filt_q};
		filt_d = 8'({2'b00, filt_q} + 10'($signed(diff) >>> FILT_SHIFT));
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			filt_q <= RST_ZERO;
		else if (tick)
			filt_q <= filt_d;
	end

	// Stored converter readback
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			adc_rb_q <= RST_ZERO;
		end
		else
		begin
			unique case (fmode)
				FMODE_NONE: adc_rb_q <= adc_sync_q; // RULE1
				FMODE_ON_READ:
				begin
					if (reg_rd && hit(reg_addr, ADDR_ADC_RB))
						adc_rb_q <= filt_q; // RULE2
				end
				FMODE_ON_TICK:
				begin
					if (tick)
						adc_rb_q <= filt_d; // RULE3
				end
				FMODE_BOTH: adc_rb_q <= filt_q; // RULE3
			endcase
		end
	end

	assign loop_in = (fmode == FMODE_BOTH) ? filt_q : adc_sync_q; // RULE1 RULE3

	// Gain stepping decision
	assign at_max = {fa_q == FA_MAX, mx_q, fl_q == FL_MAX};
	assign at_min = {fa_q == 2'h0, !mx_q, fl_q == 2'h0};
	assign up_pick = stage_pick(loop_cfg_q, ~at_max, 1'b1); // RULE5
	assign dn_pick = stage_pick(loop_cfg_q, ~at_min, 1'b0); // RULE5
	// Only the last movable stage, one step short of its top, can complete all-max
	assign would_max = !xlow_q && ((~at_max) == up_pick) && (up_pick != 3'b000)
		&& (up_pick[1] || (up_pick[2] && fa_q == FA_MAX - 2'h1)
		|| (up_pick[0] && fl_q == FL_MAX - 2'h1));
	assign raise = loop_in < low_limit_q
		&& !(loop_cfg_q[MAX_PROHIBIT_BIT] && would_max); // RULE18 RULE7
	assign lower = loop_in > high_limit_q; // RULE18

	// Preamble lock, released when leaving lock mode
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			locked_q <= 1'b0;
		else if (oper != GLV_LOCK)
			locked_q <= 1'b0;
		else if (preamble_detect)
			locked_q <= 1'b1; // RULE8
	end

	// Applied gain steps
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fa_q <= 2'h0;
			mx_q <= 1'b0;
			fl_q <= 2'h0;
			xlow_q <= 1'b0;
		end
		else if (oper == GLV_MANUAL)
		begin
			fa_q <= loop_mode_q[FA_MAN_LSB +: 2]; // RULE16
			mx_q <= loop_mode_q[MX_MAN_BIT]; // RULE16
			fl_q <= loop_mode_q[FL_MAN_LSB +: 2]; // RULE16
			xlow_q <= 1'b0;
		end
		else if (tick && (oper == GLV_FREE || (oper == GLV_LOCK && !locked_q))) // RULE8
		begin
			if (raise)
			begin
				if (xlow_q)
					xlow_q <= 1'b0;
				else if (up_pick[2])
					fa_q <= fa_q + 2'h1;
				else if (up_pick[1])
					mx_q <= 1'b1;
				else if (up_pick[0])
					fl_q <= fl_q + 2'h1;
			end
			else if (lower)
			begin
				if (dn_pick[2])
					fa_q <= fa_q - 2'h1;
				else if (dn_pick[1])
					mx_q <= 1'b0;
				else if (dn_pick[0])
					fl_q <= fl_q - 2'h1;
				else if (loop_cfg_q[XLOW_PERMIT_BIT])
					xlow_q <= 1'b1; // RULE6
			end
		end
		else if (!loop_cfg_q[XLOW_PERMIT_BIT])
		begin
			xlow_q <= 1'b0; // RULE6
		end
	end

	assign front_amp_step = fa_q; // RULE17
	assign mixer_step = mx_q;
	assign filter_step = fl_q;
	assign front_amp_extra_low = xlow_q;
	assign converter_reference_power = adc_cfg_q[REF_PWR_BIT]; // RULE4
	assign osc_q_phase_level_ref = ovr_en_q[QREF_LSB +: 4]; // RULE12
	assign crystal_trim_word = xtal_q[XTAL_LSB +: 3]; // RULE15

	// Carrier offset sample, passed through unchanged as signed kHz
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			offset_rb_q <= RST_ZERO;
		else
			offset_rb_q <= carrier_offset_in; // RULE9
	end

	// Oscillator band and bias selection
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			osc_band <= RST_ZERO;
			osc_bias <= RST_ZERO;
		end
		else
		begin
			osc_band <= ovr_en_q[BAND_EN_BIT] ? band_ovr_q : cal_band; // RULE10
			osc_bias <= ovr_en_q[BIAS_EN_BIT] ? bias_ovr_q : cal_bias; // RULE11
		end
	end

	// Calibration request on transmit or receive entry
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			osc_cal_start <= 1'b0;
		else
			osc_cal_start <= enter_tx_rx && (cal_setup_q[CAL_LSB +: 4] != CAL_BYPASS); // RULE13 RULE14
	end
endmodule
`default_nettype wire
